// ===== dv/dpc_channel_properties.sv
/*
 Concurrent checks on the drive parameter channel ports, bound into every instance.
 Assumes one clock domain on clk_i and the asynchronous active-high sys_rst_i.
*/
`timescale 1ns/1ps
module dpc_channel_properties (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] own_addr_i,
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    input wire logic tx_valid_o,
    input wire logic [7:0] tx_data_o,
    input wire logic tx_ready_i,
    input wire logic [15:0] status_word_i,
    input wire logic [15:0] out_freq_i,
    input wire logic [15:0] control_word_o,
    input wire logic [15:0] reference_o,
    input wire logic process_update_o,
    input wire logic nv_store_o,
    input wire logic [11:0] nv_number_o,
    input wire logic [31:0] nv_value_o,
    input wire logic check_error_o,
    input wire logic busy_o
);
    import dpc_pkg::*;
    // ----------------------------------------------------------------
    // Port relations
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    upd_pulse_a: assert property (process_update_o |=> !process_update_o)
        else $error("process update pulse longer than one cycle");
    proc_load_a: assert property (($changed(control_word_o) || $changed(reference_o)) |-> process_update_o)
        else $error("process words changed without update pulse");
    nv_load_a: assert property (($changed(nv_number_o) || $changed(nv_value_o)) |-> nv_store_o)
        else $error("nonvolatile write data changed without store pulse");
    bad_noeffect_a: assert property (check_error_o |=> !process_update_o && !nv_store_o)
        else $error("dropped telegram still took effect");
    bad_silent_a: assert property (check_error_o |-> !tx_valid_o [*4])
        else $error("dropped telegram was answered");
    stx_first_a: assert property ($rose(tx_valid_o) |-> tx_data_o == STX_BYTE)
        else $error("answer does not open with start byte");
    byte_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
        else $error("answer byte changed while stalled");
    answer_exec_a: assert property ($rose(tx_valid_o) |-> process_update_o)
        else $error("answer started without an executed telegram");
    // Main scenarios reached
    upd_c: cover property (process_update_o);
    nv_c: cover property (nv_store_o);
    bad_c: cover property (check_error_o);
    stall_c: cover property (tx_valid_o && !tx_ready_i);
endmodule
bind dpc_channel dpc_channel_properties dpc_channel_properties_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .own_addr_i(own_addr_i), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .tx_valid_o(tx_valid_o),
    .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i), .status_word_i(status_word_i), .out_freq_i(out_freq_i),
    .control_word_o(control_word_o), .reference_o(reference_o), .process_update_o(process_update_o),
    .nv_store_o(nv_store_o), .nv_number_o(nv_number_o), .nv_value_o(nv_value_o),
    .check_error_o(check_error_o), .busy_o(busy_o));

// ===== dv/dpc_master_model.sv
/*
 Bus master model: sends command telegrams byte by byte and collects the answer.
 Assumes the channel clock on clk_i; drives only at the falling edge.
*/
`timescale 1ns/1ps
module dpc_master_model (
    input wire logic clk_i,
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    output logic tx_ready_o
);
    import dpc_pkg::*;
    // ----------------------------------------------------------------
    // Telegram sender and answer collector
    // ----------------------------------------------------------------
    logic [7:0] rsp[$];
    logic slow = 1'b0;
    initial begin
        rx_valid_o = 1'b0;
        rx_data_o = 8'h00;
        tx_ready_o = 1'b1;
    end
    // One byte a cycle, check byte appended; bad flips its low bit
    task automatic send(input logic [7:0] b[$], input logic bad);
        logic [7:0] x;
        x = 8'h00;
        foreach (b[i]) begin
            @(negedge clk_i);
            rx_valid_o = 1'b1;
            rx_data_o = b[i];
            x = x ^ b[i];
        end
        @(negedge clk_i);
        rx_data_o = x ^ {7'h00, bad};
        @(negedge clk_i);
        rx_valid_o = 1'b0;
        rx_data_o = ~rx_data_o; // Idle line shows no stale byte
    endtask
    // Ready toggles when slow; a byte counts when taken at the next rising edge
    always @(negedge clk_i) begin
        tx_ready_o = slow ? ~tx_ready_o : 1'b1;
        if (tx_valid_i && tx_ready_o)
            rsp.push_back(tx_data_i);
    end
endmodule

// ===== dv/test_drive_parameter_channel.sv
/*
 Self-checking bench for the drive parameter channel: telegram sequences with expected answers.
 Assumes the master model and the bound property checker.
*/
`timescale 1ns/1ps
module test_drive_parameter_channel;
    import dpc_pkg::*;
    typedef logic [7:0] dpc_bytes_t[$];
    // ----------------------------------------------------------------
    // Signals, design and master
    // ----------------------------------------------------------------
    logic clk_i, sys_rst_i, rx_valid, tx_valid, tx_ready, upd, nv_store, chk_err, busy;
    logic [7:0] rx_data, tx_data;
    logic [15:0] ctrl, ref_w;
    logic [11:0] nv_num;
    logic [31:0] nv_val;
    int n_errors = 0, checked = 0, n_nv = 0, n_bad = 0, n_upd = 0;
    dpc_bytes_t q, e;
    logic [15:0] fp[6] = '{16'he00e, 16'h1010, 16'h3000, 16'h1008, 16'h1001, 16'h4001};
    logic [15:0] fi[6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0004, 16'h0001, 16'h0000};
    logic [7:0] ff[6] = '{FLT_NO_WRITE, FLT_NO_PAR, FLT_TYPE, FLT_SUBSCRIPT, FLT_NOT_ARRAY, FLT_TYPE};
    dpc_channel dpc_channel_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .own_addr_i(8'h01), .rx_valid_i(rx_valid),
        .rx_data_i(rx_data), .tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_ready_i(tx_ready),
        .status_word_i(16'h5a01), .out_freq_i(16'h0321), .control_word_o(ctrl), .reference_o(ref_w),
        .process_update_o(upd), .nv_store_o(nv_store), .nv_number_o(nv_num), .nv_value_o(nv_val),
        .check_error_o(chk_err), .busy_o(busy));
    dpc_master_model dpc_master_model_i (.clk_i(clk_i), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
        .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Pulse counters, sampled mid-cycle
    always @(negedge clk_i) begin
        if (nv_store === 1'b1) n_nv++;
        if (chk_err === 1'b1) n_bad++;
        if (upd === 1'b1) n_upd++;
    end
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic dpc_bytes_t tel(logic [15:0] command_number_word, logic [15:0] idx, logic [31:0] val, logic [31:0] process_words);
        tel = {STX_BYTE, LGE_LONG, 8'h81, command_number_word[15:8], command_number_word[7:0], idx[15:8], idx[7:0], val[31:24], val[23:16],
            val[15:8], val[7:0], process_words[31:24], process_words[23:16], process_words[15:8], process_words[7:0]};
    endfunction
    function automatic dpc_bytes_t bcc(dpc_bytes_t b);
        logic [7:0] x;
        x = 8'h00;
        foreach (b[i]) x ^= b[i];
        b.push_back(x);
        return b;
    endfunction
    function automatic dpc_bytes_t ans(logic [15:0] command_number_word, logic [15:0] idx, logic [31:0] val);
        return bcc(tel(command_number_word, idx, val, 32'h5a010321));
    endfunction
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    // Send one telegram, wait until the channel is idle, compare the whole answer
    task automatic xfer(input dpc_bytes_t t, input logic bad, input dpc_bytes_t x);
        int n;
        n = 0;
        dpc_master_model_i.rsp.delete();
        dpc_master_model_i.send(t, bad);
        repeat (3) @(negedge clk_i);
        while (busy !== 1'b0 && n < 400) begin
            @(negedge clk_i);
            n++;
        end
        chk("channel idle", {31'h0, busy}, 32'h0);
        chk("answer length", 32'(dpc_master_model_i.rsp.size()), 32'(x.size()));
        foreach (x[i]) if (i < dpc_master_model_i.rsp.size()) chk("answer byte", dpc_master_model_i.rsp[i], x[i]);
    endtask
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        complete_run();
    end
    initial begin
        sys_rst_i = 1'b1;
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        sys_rst_i = 1'b0;
        xfer(tel(16'h2001, 16'h0, 32'h1234, 32'ha5a50102), 1'b0, ans(16'h1001, 16'h0, 32'h1234));
        chk("control word", {16'h0, ctrl}, 32'ha5a5);
        chk("reference", {16'h0, ref_w}, 32'h0102);
        chk("update pulses", 32'(n_upd), 32'h1);
        xfer(tel(16'h200d, 16'h0, 32'h4, 32'h0), 1'b0, ans(16'h100d, 16'h0, 32'h4));
        xfer(tel(16'h100d, 16'h0, 32'h0, 32'h0), 1'b0, ans(16'h100d, 16'h0, 32'h4));
        dpc_master_model_i.slow = 1'b1;
        xfer(tel(16'h1001, 16'h0, 32'h0, 32'h0), 1'b0, ans(16'h1001, 16'h0, 32'h1234));
        dpc_master_model_i.slow = 1'b0;
        xfer(tel(16'he002, 16'h0, 32'h0bee, 32'h0), 1'b0, ans(16'h1002, 16'h0, 32'h0bee));
        chk("nv number", {20'h0, nv_num}, 32'h2);
        chk("nv value", nv_val, 32'h0bee);
        xfer(tel(16'hd008, 16'h0302, 32'h89abcdef, 32'h0), 1'b0, ans(16'h2008, 16'h0302, 32'h89abcdef));
        chk("nv count", 32'(n_nv), 32'h2);
        xfer(tel(16'h1008, 16'h0002, 32'h0, 32'h0), 1'b0, ans(16'h2008, 16'h0002, 32'h89abcdef));
        xfer(tel(16'h1008, 16'h0000, 32'h0, 32'h0), 1'b0, ans(16'h2008, 16'h0000, 32'h0));
        for (int k = 0; k < 6; k++) begin
            xfer(tel(fp[k], fi[k], 32'h0, 32'h0), 1'b0, ans({RSP_FAIL, fp[k][11:0]}, fi[k], {24'h0, ff[k]}));
        end
        q = {STX_BYTE, 8'h0c, 8'h81, 8'hf0, 8'h0f, IDX_TXT_WRITE, 8'h00, 8'h41, 8'h42, 8'h00, 8'h00, 8'h00, 8'h00};
        e = bcc({STX_BYTE, LGE_TXT_FIXED, 8'h81, 8'hf0, 8'h0f, IDX_TXT_WRITE, 8'h00, 8'h5a, 8'h01, 8'h03, 8'h21});
        xfer(q, 1'b0, e);
        q = {STX_BYTE, LGE_TXT_FIXED, 8'h81, 8'hf0, 8'h0f, IDX_TXT_READ, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        e = bcc({STX_BYTE, 8'h12, 8'h81, 8'hf0, 8'h0f, IDX_TXT_READ, 8'h00, 8'h41, 8'h42, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00, 8'h00, 8'h5a, 8'h01, 8'h03, 8'h21});
        xfer(q, 1'b0, e);
        q[4] = 8'h01;
        xfer(q, 1'b0, ans(16'h7001, 16'h0400, {24'h0, FLT_TYPE}));
        e = {};
        xfer(tel(16'h2001, 16'h0, 32'h7777, 32'h0), 1'b1, e);
        chk("check errors", 32'(n_bad), 32'h1);
        q = tel(16'h200c, 16'h0, 32'h03e8, 32'h0);
        q[2] = 8'h80;
        xfer(q, 1'b0, e);
        xfer(tel(16'h100c, 16'h0, 32'h0, 32'h0), 1'b0, ans(16'h100c, 16'h0, 32'h03e8));
        xfer(tel(16'h1001, 16'h0, 32'h0, 32'h0), 1'b0, ans(16'h1001, 16'h0, 32'h1234));
        q = {STX_BYTE, LGE_SHORT, 8'h81, 8'hc3, 8'h3c, 8'h00, 8'h64};
        xfer(q, 1'b0, bcc({STX_BYTE, LGE_SHORT, 8'h81, 8'h5a, 8'h01, 8'h03, 8'h21}));
        chk("short control word", {16'h0, ctrl}, 32'hc33c);
        chk("short reference", {16'h0, ref_w}, 32'h0064);
        complete_run();
    end
endmodule

// ===== rtl/dpc_channel.sv
/*
 Drive parameter channel: receives master telegrams byte by byte, checks the
 block check byte, executes parameter, text and process word commands and
 returns the response telegram byte by byte.
 Assumes the character layer runs on clk_i and delivers each received byte
 as a one-cycle rx_valid_i strobe; the transmitter takes bytes with tx_ready_i.
*/
// Behaviour
// - Index word qualifies parameter number
// - Only index low byte selects element
// - Value block is four bytes, command-defined
// - Read answers current value in block
// - Option parameters carry option ordinal
// - Text access only for type 9
// - Text telegram length in second byte
// - Data type codes as listed
// - Values travel as scaled whole numbers
// - Two process words in fixed order
// - Command E writes word to nonvolatile
// - Bits 15-12 command, 11-0 number
// - Failure answers 0111 plus fault code
// - Check byte is XOR from zero
`timescale 1ns/1ps
module dpc_channel (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] own_addr_i,
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    input wire logic tx_ready_i,
    input wire logic [15:0] status_word_i,
    input wire logic [15:0] out_freq_i,
    output logic [15:0] control_word_o,
    output logic [15:0] reference_o,
    output logic process_update_o,
    output logic nv_store_o,
    output logic [11:0] nv_number_o,
    output logic [31:0] nv_value_o,
    output logic check_error_o,
    output logic busy_o
);
    import dpc_pkg::*;

    typedef enum logic [2:0] {ST_IDLE, ST_BODY, ST_EXEC, ST_SEND} dpc_state_t;

    typedef struct packed {
        dpc_state_t st;
        logic [4:0] cnt;
        logic [7:0] bcc;
        logic [7:0] txb;
        logic [TBUF_BYTES-1:0][7:0] tbuf;
        logic [PAR_NUM-1:0][PAR_ELEMS-1:0][31:0] par;
        logic [TXT_LEN-1:0][7:0] txt;
        logic [15:0] ctrl;
        logic [15:0] refv;
        logic upd;
        logic nv;
        logic [11:0] nv_num;
        logic [31:0] nv_val;
        logic cerr;
    } dpc_regs_t;

    dpc_regs_t s_q, s_d;

    // ----------------------------------------------------------------
    // Parameter attributes
    // ----------------------------------------------------------------
    // Data type of each parameter number
    function automatic logic [7:0] par_type(input logic [11:0] num);
        case (num[3:2])
            2'h0: par_type = DT_UINT16;
            2'h1: par_type = DT_UINT32;
            2'h2: par_type = DT_INT32;
            default: par_type = (num[1:0] == 2'h3) ? DT_TEXT : (num[1:0] == 2'h2) ? DT_UINT8 : DT_INT16;
        endcase
    endfunction

    // Double word types need the double word commands
    function automatic logic is_dword(input logic [7:0] dt);
        is_dword = (dt == DT_INT32) || (dt == DT_UINT32);
    endfunction

    // Bytes i and i+1 of the buffer as one word, high byte first
    function automatic logic [15:0] word_at(input logic [TBUF_BYTES-1:0][7:0] b, input logic [4:0] i);
        word_at = {b[i], b[5'(i + 5'h01)]};
    endfunction

    // ----------------------------------------------------------------
    // Telegram engine
    // ----------------------------------------------------------------
    // Next state: receive, execute, transmit
    always_comb begin
        logic [7:0] telegram_length_byte;
        logic [7:0] adr;
        logic [3:0] cmd;
        logic [11:0] parameter_number_field;
        logic [7:0] idx_hi;
        logic [7:0] idx_lo;
        logic [31:0] value_block;
        logic [31:0] rpwe;
        logic [4:0] pcd_at;
        logic [7:0] nch;
        logic [7:0] dt;
        logic [7:0] fault;
        logic [7:0] rlge;
        logic [3:0] resp;
        logic [1:0] elem;
        logic bad;
        logic arr;
        logic hit;
        logic bcst;
        logic txt_rd;
        telegram_length_byte = s_q.tbuf[1];
        adr = s_q.tbuf[2];
        cmd = s_q.tbuf[OFS_PKE][7:4];
        parameter_number_field = {s_q.tbuf[OFS_PKE][3:0], s_q.tbuf[5'h04]};
        idx_hi = s_q.tbuf[5'h05];
        idx_lo = s_q.tbuf[5'h06];
        value_block = {word_at(s_q.tbuf, OFS_VALUE), word_at(s_q.tbuf, 5'h09)};
        rpwe = '0;
        pcd_at = 5'h00;
        nch = telegram_length_byte - LGE_TXT_FIXED;
        dt = par_type(parameter_number_field);
        fault = FLT_NO_PAR;
        rlge = LGE_LONG;
        resp = RSP_NONE;
        arr = (parameter_number_field[3:2] == 2'h2);
        elem = arr ? idx_lo[1:0] : 2'h0;
        bad = 1'b0;
        hit = 1'b0;
        bcst = 1'b0;
        txt_rd = 1'b0;
        s_d = s_q;
        s_d.upd = 1'b0;
        s_d.nv = 1'b0;
        s_d.cerr = 1'b0;
        case (s_q.st)
            // Wait for the start character
            ST_IDLE: begin
                if (rx_valid_i && rx_data_i == STX_BYTE) begin
                    s_d.tbuf[0] = rx_data_i;
                    s_d.bcc = rx_data_i;
                    s_d.cnt = 5'h01;
                    s_d.st = ST_BODY;
                end
            end
            // Collect length, address, data and check byte
            ST_BODY: begin
                if (rx_valid_i) begin
                    s_d.tbuf[s_q.cnt] = rx_data_i;
                    s_d.bcc = s_q.bcc ^ rx_data_i;
                    s_d.cnt = 5'(s_q.cnt + 5'h01);
                    if (s_q.cnt == 5'h01 && (rx_data_i < LGE_SHORT || rx_data_i > LGE_MAX)) begin
                        s_d.st = ST_IDLE;
                    end else if (s_q.cnt != 5'h01 && {3'h0, s_q.cnt} == 8'(telegram_length_byte + 8'h01)) begin
                        s_d.cerr = (s_d.bcc != 8'h00);
                        s_d.st = (s_d.bcc == 8'h00) ? ST_EXEC : ST_IDLE;
                    end
                end
            end
            // Decode and execute, then build the answer in place
            ST_EXEC: begin
                if (adr[7]) begin
                    bcst = (adr[6:0] == 7'h00);
                    hit = bcst || (adr[6:0] == own_addr_i[6:0]);
                end else begin
                    bcst = adr[5];
                    hit = bcst || (adr[4:0] == own_addr_i[4:0]);
                end
                if (telegram_length_byte == LGE_SHORT) begin
                    pcd_at = OFS_PKE;
                end else if (telegram_length_byte == LGE_LONG) begin
                    pcd_at = OFS_PCD_LONG;
                end else begin
                    pcd_at = 5'(telegram_length_byte - 8'h03);
                end
                if (hit) begin
                    s_d.ctrl = word_at(s_q.tbuf, pcd_at);
                    s_d.refv = word_at(s_q.tbuf, 5'(pcd_at + 5'h02));
                    s_d.upd = 1'b1;
                end
                // Parameter part, absent from process-only telegrams
                if (hit && telegram_length_byte != LGE_SHORT) begin
                    if (parameter_number_field >= PAR_NUM_END) begin
                        bad = 1'b1;
                    end else if (!arr && idx_lo != 8'h00) begin
                        bad = 1'b1;
                        fault = FLT_NOT_ARRAY;
                    end else if (arr && idx_lo >= 8'(PAR_ELEMS)) begin
                        bad = 1'b1;
                        fault = FLT_SUBSCRIPT;
                    end else begin
                        case (cmd)
                            CMD_NONE: resp = RSP_NONE;
                            CMD_READ: begin
                                bad = (dt == DT_TEXT);
                                fault = FLT_TYPE;
                                rpwe = s_q.par[parameter_number_field[3:0]][elem];
                                resp = is_dword(dt) ? RSP_DWORD : RSP_WORD;
                            end
                            CMD_WR_W, CMD_WR_W_NV, CMD_WR_D, CMD_WR_D_NV: begin
                                if (dt == DT_TEXT || is_dword(dt) != (cmd == CMD_WR_D || cmd == CMD_WR_D_NV)) begin
                                    bad = 1'b1;
                                    fault = FLT_TYPE;
                                end else if (parameter_number_field == PAR_READ_ONLY) begin
                                    bad = 1'b1;
                                    fault = FLT_NO_WRITE;
                                end else if (dt == DT_UINT8 && value_block > {24'h0, UINT8_MAX}) begin
                                    bad = 1'b1;
                                    fault = FLT_RANGE;
                                end else begin
                                    s_d.par[parameter_number_field[3:0]][elem] = value_block;
                                    rpwe = value_block;
                                    resp = is_dword(dt) ? RSP_DWORD : RSP_WORD;
                                    if (cmd == CMD_WR_W_NV || cmd == CMD_WR_D_NV) begin
                                        s_d.nv = 1'b1;
                                        s_d.nv_num = parameter_number_field;
                                        s_d.nv_val = value_block;
                                    end
                                end
                            end
                            CMD_TEXT: begin
                                if (dt != DT_TEXT) begin
                                    bad = 1'b1;
                                    fault = FLT_TYPE;
                                end else if (idx_hi == IDX_TXT_READ) begin
                                    txt_rd = 1'b1;
                                    resp = RSP_TEXT;
                                    rlge = 8'(LGE_TXT_FIXED + 8'(TXT_LEN));
                                end else if (idx_hi == IDX_TXT_WRITE) begin
                                    for (int i = 0; i < TXT_LEN; i++) begin
                                        s_d.txt[i] = (8'(i) < nch) ? s_q.tbuf[5'(7 + i)] : 8'h00;
                                    end
                                    resp = RSP_TEXT;
                                    rlge = LGE_TXT_FIXED;
                                end else begin
                                    bad = 1'b1;
                                    fault = FLT_SUBSCRIPT;
                                end
                            end
                            default: begin
                                bad = 1'b1;
                                fault = FLT_TYPE;
                            end
                        endcase
                    end
                    if (bad) begin
                        resp = RSP_FAIL;
                        rpwe = {24'h0, fault};
                        rlge = LGE_LONG;
                        txt_rd = 1'b0;
                    end
                end
                // Response layout; broadcasts and other stations get none
                if (telegram_length_byte == LGE_SHORT) begin
                    rlge = LGE_SHORT;
                end
                s_d.tbuf[1] = rlge;
                s_d.tbuf[OFS_PKE] = {resp, parameter_number_field[11:8]};
                if (txt_rd) begin
                    for (int i = 0; i < TXT_LEN; i++) begin
                        s_d.tbuf[5'(7 + i)] = s_q.txt[i];
                    end
                end else if (rlge == LGE_LONG) begin
                    {s_d.tbuf[5'h07], s_d.tbuf[5'h08], s_d.tbuf[5'h09], s_d.tbuf[5'h0a]} = rpwe;
                end
                pcd_at = 5'(rlge - 8'h03);
                {s_d.tbuf[pcd_at], s_d.tbuf[5'(pcd_at + 5'h01)]} = status_word_i;
                {s_d.tbuf[5'(pcd_at + 5'h02)], s_d.tbuf[5'(pcd_at + 5'h03)]} = out_freq_i;
                s_d.cnt = 5'h00;
                s_d.bcc = 8'h00;
                s_d.txb = STX_BYTE;
                s_d.st = (hit && !bcst) ? ST_SEND : ST_IDLE;
            end
            // Stream the answer, check byte last
            ST_SEND: begin
                if (tx_ready_i) begin
                    s_d.bcc = s_q.bcc ^ s_q.txb;
                    s_d.cnt = 5'(s_q.cnt + 5'h01);
                    if ({3'h0, s_q.cnt} == 8'(telegram_length_byte + 8'h01)) begin
                        s_d.st = ST_IDLE;
                    end else if ({3'h0, s_q.cnt} == telegram_length_byte) begin
                        s_d.txb = s_d.bcc;
                    end else begin
                        s_d.txb = s_q.tbuf[5'(s_q.cnt + 5'h01)];
                    end
                end
            end
            default: s_d.st = ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Handshake is combinational, data from flip-flops
    assign tx_valid_o = (s_q.st == ST_SEND);
    assign tx_data_o = s_q.txb;
    assign control_word_o = s_q.ctrl;
    assign reference_o = s_q.refv;
    assign process_update_o = s_q.upd;
    assign nv_store_o = s_q.nv;
    assign nv_number_o = s_q.nv_num;
    assign nv_value_o = s_q.nv_val;
    assign check_error_o = s_q.cerr;
    assign busy_o = (s_q.st != ST_IDLE);
endmodule

// ===== rtl/dpc_pkg.sv
/*
 Constants shared by the drive parameter channel: telegram framing, command and
 response codes, fault reports, data type codes and parameter table sizes.
 Assumes a single 100 MHz clock domain for every user of the package.
*/
package dpc_pkg;
    // ----------------------------------------------------------------
    // Framing
    // ----------------------------------------------------------------
    localparam logic [7:0] STX_BYTE = 8'h02;
    localparam logic [7:0] LGE_SHORT = 8'h06; // Process words only
    localparam logic [7:0] LGE_LONG = 8'h0e; // Parameter block
    localparam logic [7:0] LGE_TXT_FIXED = 8'h0a; // Text block without characters
    localparam logic [7:0] LGE_MAX = 8'h16; // Largest accepted telegram length
    localparam int TBUF_BYTES = 24;
    localparam logic [4:0] OFS_PKE = 5'h03;
    localparam logic [4:0] OFS_VALUE = 5'h07;
    localparam logic [4:0] OFS_PCD_LONG = 5'h0b;
    // ----------------------------------------------------------------
    // Command and response codes, top nibble of the command number word; text index codes
    // ----------------------------------------------------------------
    localparam logic [3:0] CMD_NONE = 4'h0;
    localparam logic [3:0] CMD_READ = 4'h1;
    localparam logic [3:0] CMD_WR_W = 4'h2;
    localparam logic [3:0] CMD_WR_D = 4'h3;
    localparam logic [3:0] CMD_WR_D_NV = 4'hd;
    localparam logic [3:0] CMD_WR_W_NV = 4'he;
    localparam logic [3:0] CMD_TEXT = 4'hf;
    localparam logic [3:0] RSP_NONE = 4'h0;
    localparam logic [3:0] RSP_WORD = 4'h1;
    localparam logic [3:0] RSP_DWORD = 4'h2;
    localparam logic [3:0] RSP_FAIL = 4'h7;
    localparam logic [3:0] RSP_TEXT = 4'hf;
    localparam logic [7:0] IDX_TXT_READ = 8'h04;
    localparam logic [7:0] IDX_TXT_WRITE = 8'h05;
    // ----------------------------------------------------------------
    // Fault reports in the low word of the value block
    // ----------------------------------------------------------------
    localparam logic [7:0] FLT_NO_PAR = 8'h00;
    localparam logic [7:0] FLT_NO_WRITE = 8'h01;
    localparam logic [7:0] FLT_RANGE = 8'h02;
    localparam logic [7:0] FLT_SUBSCRIPT = 8'h03;
    localparam logic [7:0] FLT_NOT_ARRAY = 8'h04;
    localparam logic [7:0] FLT_TYPE = 8'h05;
    // ----------------------------------------------------------------
    // Data type codes
    // ----------------------------------------------------------------
    localparam logic [7:0] DT_INT16 = 8'd3;
    localparam logic [7:0] DT_INT32 = 8'd4;
    localparam logic [7:0] DT_UINT8 = 8'd5;
    localparam logic [7:0] DT_UINT16 = 8'd6;
    localparam logic [7:0] DT_UINT32 = 8'd7;
    localparam logic [7:0] DT_TEXT = 8'd9;
    localparam logic [7:0] DT_BYTES = 8'd10;
    localparam logic [7:0] DT_TIMEDIFF = 8'd13;
    localparam logic [7:0] DT_RESERVED = 8'd33;
    localparam logic [7:0] DT_BITSEQ = 8'd35;
    // ----------------------------------------------------------------
    // Parameter table
    // ----------------------------------------------------------------
    localparam int PAR_NUM = 16;
    localparam int PAR_ELEMS = 4;
    localparam int TXT_LEN = 8;
    localparam logic [11:0] PAR_NUM_END = 12'h010;
    localparam logic [11:0] PAR_READ_ONLY = 12'h00e;
    localparam logic [7:0] UINT8_MAX = 8'hff;
endpackage
